// ---- common/pinmux_pkg.sv ----
// package: register map, field layout, pin indices and carrier types of the pin function multiplexer
package pinmux_pkg;

	// register byte addresses on the APB
	localparam logic [31:0] FSEL0_ADDR = 32'h01C4_0000;
	localparam logic [31:0] FSEL1_ADDR = 32'h01C4_0004;

	// pin_function_select_0 field positions
	localparam int F0_RMII     = 0;
	localparam int F0_MODE_LO  = 1;
	localparam int F0_CS5      = 6;
	localparam int F0_CS4      = 8;
	localparam int F0_CS3      = 10;
	localparam int F0_BOOT_LO  = 16;
	localparam logic [31:0] FSEL0_WMASK = 32'h0000_054F;
	localparam logic [31:0] FSEL0_RMASK = 32'h0007_054F;

	// pin_function_select_1 field positions
	localparam int F1_TMR0     = 0;
	localparam int F1_HOST     = 1;
	localparam logic [31:0] FSEL1_WMASK = 32'h0000_0003;

	// reset values before the boot straps are taken
	localparam logic [31:0] FSEL0_RESET = 32'h0000_0000;
	localparam logic [31:0] FSEL1_RESET = 32'h0000_0000;

	// boot_memory_config_code values
	localparam logic [2:0] BOOT_GPIO  = 3'h0;
	localparam logic [2:0] BOOT_ASYNC = 3'h2;
	localparam logic [2:0] BOOT_NAND  = 3'h5;

	// clocks between reset release and strap capture (two synchroniser stages)
	localparam int STRAP_SETTLE = 2;

	// pin indices
	localparam int PIN_CS3     = 0;
	localparam int PIN_CS4     = 1;
	localparam int PIN_CS5     = 2;
	localparam int PIN_WAIT    = 3;
	localparam int PIN_OE      = 4;
	localparam int PIN_WE      = 5;
	localparam int PIN_TMR0    = 6;
	localparam int PIN_RMII_LO = 7;
	localparam int RMII_PINS   = 3;
	localparam int PIN_MEM_LO  = 10;
	localparam int MEM_PINS    = 8;
	localparam int PIN_HOST_LO = 18;
	localparam int HOST_PINS   = 4;
	localparam int NUM_PINS    = 22;

	// which source owns a pin
	typedef enum logic [1:0] {
		SRC_GPIO,
		SRC_FN_A,
		SRC_FN_B
	} pin_src_e;

	// major option of the memory-port block
	typedef enum logic [2:0] {
		OPT_A,
		OPT_B,
		OPT_C,
		OPT_D,
		OPT_E,
		OPT_F,
		OPT_OTHER
	} mem_option_e;

	// output value and drive request of one source for all pins
	typedef struct packed {
		logic [NUM_PINS-1:0] dout;
		logic [NUM_PINS-1:0] drive;
	} pin_drive_s;

	// boot configuration straps
	typedef struct packed {
		logic [2:0] boot_code;
		logic       rmii;
		logic       host;
	} strap_s;

endpackage

// ---- core/boot_strap_latch.sv ----
// boot strap synchroniser and capture after reset release
`timescale 1ns/1ps
`default_nettype none
module boot_strap_latch (
	input  wire logic              mclk_i,    // system clock
	input  wire logic              resetn_i,  // async reset, active low
	input  wire pinmux_pkg::strap_s strap_i,  // raw strap pins
	output var  pinmux_pkg::strap_s strap_o,  // captured straps
	output var  logic              load_o,    // one-cycle capture pulse
	output var  logic              done_o     // straps captured
);
	import pinmux_pkg::*;

	strap_s     sync1_r;
	strap_s     sync2_r;
	logic [1:0] cnt_r;
	logic       cap_w;

	// capture once the synchronised straps reflect the pins at release
	assign cap_w = !done_o && (cnt_r == 2'(STRAP_SETTLE));

	// two-stage synchroniser for the strap pins
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= strap_i;
			sync2_r <= sync1_r;
		end
	end

	// settle counter and capture
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_r   <= '0;
			strap_o <= '0;
			load_o  <= 1'b0;
			done_o  <= 1'b0;
		end else begin
			load_o <= cap_w;
			if (!done_o && cnt_r != 2'(STRAP_SETTLE))
				cnt_r <= cnt_r + 2'd1;
			if (cap_w) begin
				strap_o <= sync2_r; // [R2]
				done_o  <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- core/pin_cell.sv ----
// one multiplexed pin: output select, drive enable and input routing
`timescale 1ns/1ps
`default_nettype none
module pin_cell (
	input  wire logic                 mclk_i,      // system clock
	input  wire logic                 resetn_i,    // async reset, active low
	input  wire pinmux_pkg::pin_src_e sel_i,       // owner of the pin
	input  wire logic                 gpio_dout_i, // gpio output value
	input  wire logic                 gpio_drv_i,  // gpio drives the pin
	input  wire logic                 fa_dout_i,   // function A output
	input  wire logic                 fa_drv_i,    // function A drives
	input  wire logic                 fb_dout_i,   // function B output
	input  wire logic                 fb_drv_i,    // function B drives
	input  wire logic                 pad_i,       // pin level, async
	output var  logic                 pad_o,       // pin output value
	output var  logic                 pad_oe_n_o,  // pin drive, active low
	output var  logic                 gpio_in_o,   // pin seen by gpio
	output var  logic                 fa_in_o,     // pin seen by function A
	output var  logic                 fb_in_o      // pin seen by function B
);
	import pinmux_pkg::*;

	logic pad_s1_r;
	logic pad_s2_r;
	logic dout_w;
	logic drv_w;

	// output selection from the current owner
	assign dout_w = (sel_i == SRC_FN_A) ? fa_dout_i : (sel_i == SRC_FN_B) ? fb_dout_i : gpio_dout_i; // [R19]
	assign drv_w  = (sel_i == SRC_FN_A) ? fa_drv_i  : (sel_i == SRC_FN_B) ? fb_drv_i  : gpio_drv_i;  // [R19]

	// pin input synchroniser
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pad_s1_r <= 1'b0;
			pad_s2_r <= 1'b0;
		end else begin
			pad_s1_r <= pad_i;
			pad_s2_r <= pad_s1_r;
		end
	end

	// registered pin drive and input routing; unselected owners see zero
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pad_o      <= 1'b0;
			pad_oe_n_o <= 1'b1;
			gpio_in_o  <= 1'b0;
			fa_in_o    <= 1'b0;
			fb_in_o    <= 1'b0;
		end else begin
			pad_o      <= dout_w;
			pad_oe_n_o <= !drv_w;
			gpio_in_o  <= pad_s2_r && (sel_i == SRC_GPIO); // [R19]
			fa_in_o    <= pad_s2_r && (sel_i == SRC_FN_A); // [R19]
			fb_in_o    <= pad_s2_r && (sel_i == SRC_FN_B); // [R19]
		end
	end
endmodule
`default_nettype wire

// ---- core/pin_function_multiplexer.sv ----
// pin function multiplexer: selection registers on APB, strap defaults, per-pin muxing
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: at reset, some fields of both selection registers default from boot strap pins
// R2: strap pin states are captured as reset rises
// R3: after reset, register writes change pin functions at once
// R4: software selects a multi-block peripheral in every block it spans
// R5: boot code 000, rmii 0: option A, all memory-port pins are gpio; code keeps wait, oe and we pins on the memory port
// R6: boot code 000, rmii 1: option B, rmii plus gpio
// R7: boot code 010, rmii 0: option C, async memory mode 2 plus gpio
// R8: boot code 010, rmii 1: option D, async memory, rmii, few gpio
// R9: boot code 101, rmii 0: option E, nand mode 5 plus gpio
// R10: boot code 101, rmii 1: option F, nand mode 5, rmii, gpio
// R11: wait, output-enable, write-enable pins always serve the memory port
// R12: select register 0 steers only memory-port block pins
// R13: some pins decode their function from several fields together
// R14: software writes zero to reserved bits
// R15: bits 18:16 of select register 0 have no effect, may read nonzero
// R16: timer0 pin is shared by timer0 and the serial port external clock
// R17: bit 10 alone: 0 gives gpio line 13, 1 gives chip select 3
// R18: bit 8 at 0: gpio 32 or rmii rxd0 by rmii; 1: chip select 4
// R19: pin drive and input routing follow registers; unselected functions see inactive inputs
module pin_function_multiplexer (
	input  wire logic                          mclk_i,     // system clock, 10 MHz
	input  wire logic                          resetn_i,   // async reset, active low
	input  wire logic [31:0]                   paddr,      // apb address
	input  wire logic                          psel,       // apb select
	input  wire logic                          penable,    // apb access phase
	input  wire logic                          pwrite,     // apb write
	input  wire logic [31:0]                   pwdata,     // apb write data
	output var  logic [31:0]                   prdata,     // apb read data
	output var  logic                          pready,     // apb ready
	output var  logic                          pslverr,    // apb error, unmapped address
	input  wire pinmux_pkg::strap_s            strap_i,    // raw boot strap pins
	input  wire pinmux_pkg::pin_drive_s        gpio_i,     // gpio outputs per pin
	input  wire pinmux_pkg::pin_drive_s        fn_a_i,     // function A outputs per pin
	input  wire pinmux_pkg::pin_drive_s        fn_b_i,     // function B outputs per pin
	input  wire logic [pinmux_pkg::NUM_PINS-1:0] pad_i,    // pin levels
	output var  logic [pinmux_pkg::NUM_PINS-1:0] pad_o,    // pin output values
	output var  logic [pinmux_pkg::NUM_PINS-1:0] pad_oe_n_o, // pin drive, active low
	output var  logic [pinmux_pkg::NUM_PINS-1:0] gpio_in_o,  // pin inputs to gpio
	output var  logic [pinmux_pkg::NUM_PINS-1:0] fn_a_in_o,  // pin inputs to function A
	output var  logic [pinmux_pkg::NUM_PINS-1:0] fn_b_in_o,  // pin inputs to function B
	output var  pinmux_pkg::mem_option_e       mem_option_o  // major option of memory-port block
);
	import pinmux_pkg::*;

	logic [31:0]   fsel0_r;
	logic [31:0]   fsel1_r;
	logic [31:0]   prdata_nxt;
	logic          pready_nxt;
	logic          pslverr_nxt;
	strap_s        strap_w;
	logic          strap_load_w;
	logic          strap_done_w;
	logic          setup_w;
	logic          hit0_w;
	logic          hit1_w;
	logic          wr0_w;
	logic          wr1_w;
	logic [31:0]   fsel0_def_w;
	logic [31:0]   fsel1_def_w;
	logic [2:0]    mode_w;
	logic          rmii_w;
	logic          mem_on_w;
	mem_option_e   option_nxt;
	pin_src_e      sel_w [NUM_PINS];

	// strap capture
	boot_strap_latch u_strap (
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.strap_i  (strap_i),
		.strap_o  (strap_w),
		.load_o   (strap_load_w),
		.done_o   (strap_done_w)
	);

	// apb decode: answer one cycle after setup, writes at the completing edge
	assign setup_w = psel && !penable;
	assign hit0_w  = (paddr == FSEL0_ADDR);
	assign hit1_w  = (paddr == FSEL1_ADDR);
	assign wr0_w   = psel && penable && pready && pwrite && hit0_w && !pslverr;
	assign wr1_w   = psel && penable && pready && pwrite && hit1_w && !pslverr;
	assign pready_nxt  = setup_w;
	assign pslverr_nxt = setup_w && !(hit0_w || hit1_w);
	assign prdata_nxt  = !setup_w ? 32'h0000_0000 :
	                     hit0_w   ? (fsel0_r & FSEL0_RMASK) :
	                     hit1_w   ? (fsel1_r & FSEL1_WMASK) : 32'h0000_0000;

	// defaults built from the captured straps; chip select fields default to zero, leaving those pins gpio or rmii
	assign fsel0_def_w = FSEL0_RESET | ({29'h0000_0000, strap_w.boot_code} << F0_BOOT_LO)
	                     | ({29'h0000_0000, strap_w.boot_code} << F0_MODE_LO)
	                     | ({31'h0000_0000, strap_w.rmii} << F0_RMII);          // [R1] [R17] [R18]
	assign fsel1_def_w = FSEL1_RESET | ({31'h0000_0000, strap_w.host} << F1_HOST); // [R1]

	// apb response registers
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= pready_nxt;
			pslverr <= pslverr_nxt;
			prdata  <= prdata_nxt;
		end
	end

	// selection registers: strap defaults, then software writes; reserved bits never stored
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fsel0_r <= FSEL0_RESET;
			fsel1_r <= FSEL1_RESET;
		end else if (strap_load_w) begin
			fsel0_r <= fsel0_def_w; // [R1] [R2]
			fsel1_r <= fsel1_def_w; // [R1]
		end else begin
			if (wr0_w)
				fsel0_r <= (pwdata & FSEL0_WMASK) | (fsel0_r & ~FSEL0_WMASK); // [R3] [R14] [R15]
			if (wr1_w)
				fsel1_r <= pwdata & FSEL1_WMASK; // [R3] [R14]
		end
	end

	// memory-port block decode from several fields
	assign mode_w   = fsel0_r[F0_MODE_LO +: 3];
	assign rmii_w   = fsel0_r[F0_RMII];
	assign mem_on_w = (mode_w == BOOT_ASYNC) || (mode_w == BOOT_NAND); // [R7] [R9]

	// major option of the memory-port block
	always_comb begin
		case (mode_w)
			BOOT_GPIO:  option_nxt = rmii_w ? OPT_B : OPT_A; // [R5] [R6]
			BOOT_ASYNC: option_nxt = rmii_w ? OPT_D : OPT_C; // [R7] [R8]
			BOOT_NAND:  option_nxt = rmii_w ? OPT_F : OPT_E; // [R9] [R10]
			default:    option_nxt = OPT_OTHER;
		endcase
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i)
			mem_option_o <= OPT_OTHER;
		else
			mem_option_o <= option_nxt;
	end

	// per-pin owner; function B is the memory port on memory-port block pins
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++)
			sel_w[i] = SRC_GPIO;
		sel_w[PIN_CS3] = fsel0_r[F0_CS3] ? SRC_FN_B : SRC_GPIO; // [R17] [R12]
		sel_w[PIN_CS4] = fsel0_r[F0_CS4] ? SRC_FN_B : rmii_w ? SRC_FN_A : SRC_GPIO; // [R18] [R13]
		sel_w[PIN_CS5] = fsel0_r[F0_CS5] ? SRC_FN_B : rmii_w ? SRC_FN_A : SRC_GPIO; // [R13]
		sel_w[PIN_WAIT] = SRC_FN_B; // [R11]
		sel_w[PIN_OE]   = SRC_FN_B; // [R11]
		sel_w[PIN_WE]   = SRC_FN_B; // [R11]
		sel_w[PIN_TMR0] = fsel1_r[F1_TMR0] ? SRC_FN_B : SRC_FN_A; // [R16]
		for (int i = 0; i < RMII_PINS; i++)
			sel_w[PIN_RMII_LO + i] = rmii_w ? SRC_FN_A : SRC_GPIO; // [R6] [R8] [R10]
		for (int i = 0; i < MEM_PINS; i++)
			sel_w[PIN_MEM_LO + i] = mem_on_w ? SRC_FN_B : SRC_GPIO; // [R5] [R7] [R9] [R12]
		for (int i = 0; i < HOST_PINS; i++)
			sel_w[PIN_HOST_LO + i] = fsel1_r[F1_HOST] ? SRC_FN_A : SRC_GPIO;
	end

	// one pin cell per pin
	for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
		pin_cell u_cell (
			.mclk_i      (mclk_i),
			.resetn_i    (resetn_i),
			.sel_i       (sel_w[g]),
			.gpio_dout_i (gpio_i.dout[g]),
			.gpio_drv_i  (gpio_i.drive[g]),
			.fa_dout_i   (fn_a_i.dout[g]),
			.fa_drv_i    (fn_a_i.drive[g]),
			.fb_dout_i   (fn_b_i.dout[g]),
			.fb_drv_i    (fn_b_i.drive[g]),
			.pad_i       (pad_i[g]),
			.pad_o       (pad_o[g]),
			.pad_oe_n_o  (pad_oe_n_o[g]),
			.gpio_in_o   (gpio_in_o[g]),
			.fa_in_o     (fn_a_in_o[g]),
			.fb_in_o     (fn_b_in_o[g])
		);
	end

	// strap capture lands the boot code and rmii strap in register 0
	AST_STRAP_DEFAULT: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R1] [R2]
		$rose(strap_done_w) |=> fsel0_r[F0_MODE_LO +: 3] == strap_w.boot_code
		&& fsel0_r[F0_RMII] == strap_w.rmii && fsel0_r[F0_BOOT_LO +: 3] == strap_w.boot_code
		&& fsel0_r[F0_CS3] == 1'b0)
		else $error("strap defaults not loaded");

	// a write to register 0 lands at the completing edge
	AST_WRITE_EFFECT: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R3]
		wr0_w |=> (fsel0_r & FSEL0_WMASK) == ($past(pwdata) & FSEL0_WMASK))
		else $error("write to select register 0 lost");

	// chip select 3 pin follows bit 10 alone
	AST_CS3_PIN: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R17]
		##1 $past(fsel0_r[F0_CS3]) |-> pad_oe_n_o[PIN_CS3] == !$past(fn_b_i.drive[PIN_CS3]))
		else $error("chip select 3 pin not memory port");

	// chip select 4 pin: rmii receive input when bit 8 clear and rmii set
	AST_CS4_RMII: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R18] [R13]
		##1 (!$past(fsel0_r[F0_CS4]) && $past(rmii_w)) |->
		pad_oe_n_o[PIN_CS4] == !$past(fn_a_i.drive[PIN_CS4]) && fn_b_in_o[PIN_CS4] == 1'b0)
		else $error("chip select 4 pin not routed to rmii");

	// fixed memory control pins always driven by the memory port
	AST_FIXED_CTRL: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R11]
		$past(resetn_i) |-> pad_oe_n_o[PIN_OE] == !$past(fn_b_i.drive[PIN_OE])
		&& pad_o[PIN_WE] == $past(fn_b_i.dout[PIN_WE]) && gpio_in_o[PIN_WAIT] == 1'b0)
		else $error("memory control pin left the memory port");

	// reserved bits 31:19, 15:11 and 9 read zero; bits 18:16 read the latched code
	AST_RSV_READ: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R15]
		(setup_w && hit0_w && strap_done_w && !strap_load_w) |=>
		prdata[31:19] == 13'h0000 && prdata[15:11] == 5'h00 && prdata[9] == 1'b0
		&& prdata[18:16] == strap_w.boot_code)
		else $error("select register 0 read shows reserved bits");

	// timer0 pin feeds only timer0 while the serial clock is not chosen
	AST_TMR0_SHARE: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R16] [R19]
		##1 !$past(fsel1_r[F1_TMR0]) |-> fn_b_in_o[PIN_TMR0] == 1'b0 && gpio_in_o[PIN_TMR0] == 1'b0)
		else $error("serial clock sees timer0 pin while unselected");

	// memory data pins are gpio in options A and B
	AST_MEM_GPIO: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R5] [R6]
		$past(resetn_i) && $past(mode_w) == BOOT_GPIO |->
		pad_oe_n_o[PIN_MEM_LO] == !$past(gpio_i.drive[PIN_MEM_LO]) && fn_b_in_o[PIN_MEM_LO] == 1'b0)
		else $error("memory data pin not gpio in option A or B");

	// option F in nand mode with rmii
	AST_OPTION: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R10] only
		($past(mode_w) == BOOT_NAND && $past(rmii_w)) |-> mem_option_o == OPT_F)
		else $error("major option wrong for nand with rmii");

	// apb answers exactly one cycle after setup
	AST_APB_READY: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		setup_w |=> pready ##1 !pready)
		else $error("apb ready not one cycle after setup");

	// cs3 pin is gpio while bit 10 is clear
	AST_CS3_GPIO: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R17]
		$past(resetn_i) && !$past(fsel0_r[F0_CS3]) |->
		pad_o[PIN_CS3] == $past(gpio_i.dout[PIN_CS3]) && fn_b_in_o[PIN_CS3] == 1'b0)
		else $error("chip select 3 pin not gpio");

	// cs4 wins over rmii when bit 8 is set
	AST_CS4_CHIPSEL: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R18]
		$past(resetn_i) && $past(fsel0_r[F0_CS4]) |->
		pad_oe_n_o[PIN_CS4] == !$past(fn_b_i.drive[PIN_CS4]) && fn_a_in_o[PIN_CS4] == 1'b0)
		else $error("chip select 4 pin not memory port");

	// cs5 pin carries rmii data with bit 6 clear and rmii set
	AST_CS5_RMII: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R13]
		$past(resetn_i) && !$past(fsel0_r[F0_CS5]) && $past(rmii_w) |->
		pad_o[PIN_CS5] == $past(fn_a_i.dout[PIN_CS5]) && gpio_in_o[PIN_CS5] == 1'b0)
		else $error("chip select 5 pin not routed to rmii");

	// rmii pins belong to the mac while rmii is set
	AST_RMII_PINS: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R6] [R8] [R10]
		$past(resetn_i) && $past(rmii_w) |->
		pad_oe_n_o[PIN_RMII_LO] == !$past(fn_a_i.drive[PIN_RMII_LO]) && gpio_in_o[PIN_RMII_LO] == 1'b0)
		else $error("rmii pin not owned by the mac");

	// memory data pins serve the memory port in async and nand modes
	AST_MEM_PORT: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R7] [R9]
		$past(resetn_i) && $past(mem_on_w) |->
		pad_o[PIN_MEM_LO + MEM_PINS - 1] == $past(fn_b_i.dout[PIN_MEM_LO + MEM_PINS - 1])
		&& gpio_in_o[PIN_MEM_LO] == 1'b0)
		else $error("memory data pin not memory port");

	// host pins stay gpio while the register 1 host bit is clear, whatever register 0 holds
	AST_HOST_GPIO: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R12] [R19]
		$past(resetn_i) && !$past(fsel1_r[F1_HOST]) |->
		pad_oe_n_o[PIN_HOST_LO] == !$past(gpio_i.drive[PIN_HOST_LO]) && fn_a_in_o[PIN_HOST_LO] == 1'b0)
		else $error("host pin left gpio");

	// timer0 pin serves only the serial clock when chosen
	AST_TMR0_CLK: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R16]
		$past(resetn_i) && $past(fsel1_r[F1_TMR0]) |->
		pad_o[PIN_TMR0] == $past(fn_b_i.dout[PIN_TMR0]) && fn_a_in_o[PIN_TMR0] == 1'b0)
		else $error("timer0 sees its pin while serial clock chosen");

	// option A or B in gpio mode
	AST_OPTION_GPIO: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R5] [R6]
		$past(resetn_i) && $past(mode_w) == BOOT_GPIO |-> mem_option_o == ($past(rmii_w) ? OPT_B : OPT_A))
		else $error("major option wrong for gpio mode");

	// option E in nand mode without rmii
	AST_OPTION_NAND_E: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R9]
		$past(resetn_i) && $past(mode_w) == BOOT_NAND && !$past(rmii_w) |-> mem_option_o == OPT_E)
		else $error("major option wrong for nand without rmii");

	// writes never touch the latched boot code copy
	AST_BOOT_COPY: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R15]
		wr0_w |=> fsel0_r[F0_BOOT_LO +: 3] == $past(fsel0_r[F0_BOOT_LO +: 3]))
		else $error("write changed the boot code copy");

	// a write to register 1 lands at the completing edge
	AST_WRITE1_EFFECT: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R3]
		wr1_w |=> fsel1_r == ($past(pwdata) & FSEL1_WMASK))
		else $error("write to select register 1 lost");

endmodule
`default_nettype wire

// ---- verif/tb_pin_function_multiplexer.sv ----
// self-checking testbench of the pin function multiplexer, driven over apb
`timescale 1ns/1ps
`default_nettype none
module tb_pin_function_multiplexer;
	import pinmux_pkg::*;

	localparam int TIMEOUT_CYCLES = 5000;

	logic                mclk_i;
	logic                resetn_i;
	logic [31:0]         paddr;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [31:0]         pwdata;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	strap_s              strap_i;
	pin_drive_s          gpio_i;
	pin_drive_s          fn_a_i;
	pin_drive_s          fn_b_i;
	logic [NUM_PINS-1:0] pad_i;
	logic [NUM_PINS-1:0] pad_o;
	logic [NUM_PINS-1:0] pad_oe_n_o;
	logic [NUM_PINS-1:0] gpio_in_o;
	logic [NUM_PINS-1:0] fn_a_in_o;
	logic [NUM_PINS-1:0] fn_b_in_o;
	mem_option_e         mem_option_o;
	int                  n_fail = 0;
	int                  num_checks = 0;
	int                  cycles = 0;
	logic [2:0]          code_tab [7] = '{BOOT_GPIO, BOOT_GPIO, BOOT_ASYNC, BOOT_ASYNC, BOOT_NAND, BOOT_NAND, 3'h7};
	logic [31:0]         wr_tab [9][2] = '{
		'{32'h0000_0400, 32'h0000_0000}, '{32'h0000_0001, 32'h0000_0001}, '{32'h0000_0100, 32'h0000_0002},
		'{32'h0000_0044, 32'h0000_0003}, '{32'h0000_0005, 32'h0000_0000}, '{32'h0000_000A, 32'h0000_0001},
		'{32'h0000_000B, 32'h0000_0000}, '{32'h0000_000E, 32'h0000_0002}, '{32'h0000_0000, 32'h0000_0000}};

	pin_function_multiplexer pin_function_multiplexer_inst (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.strap_i(strap_i), .gpio_i(gpio_i), .fn_a_i(fn_a_i), .fn_b_i(fn_b_i), .pad_i(pad_i),
		.pad_o(pad_o), .pad_oe_n_o(pad_oe_n_o), .gpio_in_o(gpio_in_o), .fn_a_in_o(fn_a_in_o),
		.fn_b_in_o(fn_b_in_o), .mem_option_o(mem_option_o)
	);

	// 10 MHz system clock
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end

	// hang guard: counts as a mismatch and closes the run
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == TIMEOUT_CYCLES) begin
			n_fail++;
			end_sim();
		end
	end

	// verdict and end of run
	task automatic end_sim();
		if (n_fail == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// one comparison, reported at once on mismatch
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	// one apb transfer, entered and left right after a rising edge
	task automatic apb_xfer(input logic [31:0] addr, input logic wr, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic err);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= addr;
		pwrite  <= wr;
		pwdata  <= wdata;
		@(posedge mclk_i);
		penable <= 1'b1;
		@(posedge mclk_i);
		while (pready !== 1'b1) @(posedge mclk_i);
		rdata   = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk_i);
	endtask

	// register write with expected error response
	task automatic reg_wr(input logic [31:0] addr, input logic [31:0] data, input logic exp_err);
		logic [31:0] rd;
		logic        err;
		apb_xfer(addr, 1'b1, data, rd, err);
		chk("write error", {31'h0, exp_err}, {31'h0, err});
	endtask

	// register read compared with expected data and error
	task automatic reg_rd(input logic [31:0] addr, input logic [31:0] exp, input logic exp_err, input string name);
		logic [31:0] rd;
		logic        err;
		apb_xfer(addr, 1'b0, 32'h0000_0000, rd, err);
		chk(name, exp, rd);
		chk("read error", {31'h0, exp_err}, {31'h0, err});
	endtask

	// reset with given straps, then move the straps away after capture
	task automatic do_reset(input logic [2:0] code, input logic rmii, input logic host);
		resetn_i <= 1'b0;
		strap_i  <= '{boot_code: code, rmii: rmii, host: host};
		repeat (12) @(posedge mclk_i);
		resetn_i <= 1'b1;
		repeat (6) @(posedge mclk_i);
		strap_i  <= '{boot_code: ~code, rmii: ~rmii, host: ~host};
		repeat (2) @(posedge mclk_i);
	endtask

	// owner of a pin: 0 gpio, 1 function A, 2 function B
	function automatic int pin_owner(input int i, input logic [31:0] r0, input logic [31:0] r1);
		logic [2:0] mode;
		mode = r0[3:1];
		if (i == PIN_CS3) return r0[F0_CS3] ? 2 : 0;
		if (i == PIN_CS4) return r0[F0_CS4] ? 2 : (r0[F0_RMII] ? 1 : 0);
		if (i == PIN_CS5) return r0[F0_CS5] ? 2 : (r0[F0_RMII] ? 1 : 0);
		if (i >= PIN_WAIT && i <= PIN_WE) return 2;
		if (i == PIN_TMR0) return r1[F1_TMR0] ? 2 : 1;
		if (i < PIN_RMII_LO + RMII_PINS) return r0[F0_RMII] ? 1 : 0;
		if (i < PIN_MEM_LO + MEM_PINS) return (mode == BOOT_ASYNC || mode == BOOT_NAND) ? 2 : 0;
		return r1[F1_HOST] ? 1 : 0;
	endfunction

	// major option of the memory-port block from mode and rmii fields
	function automatic mem_option_e exp_opt(input logic [31:0] r0);
		case (r0[3:1])
			BOOT_GPIO:  return r0[F0_RMII] ? OPT_B : OPT_A;
			BOOT_ASYNC: return r0[F0_RMII] ? OPT_D : OPT_C;
			BOOT_NAND:  return r0[F0_RMII] ? OPT_F : OPT_E;
			default:    return OPT_OTHER;
		endcase
	endfunction

	// registers, option and every pin against the expected selection
	task automatic check_state(input logic [31:0] r0, input logic [31:0] r1);
		int         s;
		logic [4:0] exp_p;
		logic [4:0] got_p;
		reg_rd(FSEL0_ADDR, r0, 1'b0, "select0");
		reg_rd(FSEL1_ADDR, r1, 1'b0, "select1");
		chk("mem_option", 32'(exp_opt(r0)), 32'(mem_option_o));
		for (int i = 0; i < NUM_PINS; i++) begin
			s = pin_owner(i, r0, r1);
			exp_p = {s == 0, s == 1, s == 2, s == 1, s == 2};
			got_p = {gpio_in_o[i], fn_a_in_o[i], fn_b_in_o[i], pad_oe_n_o[i], (s == 1) ? 1'b0 : pad_o[i]};
			chk($sformatf("pin %0d", i), 32'(exp_p), 32'(got_p));
		end
	endtask

	// main sequence
	initial begin
		resetn_i = 1'b0;
		paddr    = 32'h0000_0000;
		psel     = 1'b0;
		penable  = 1'b0;
		pwrite   = 1'b0;
		pwdata   = 32'h0000_0000;
		strap_i  = '0;
		gpio_i   = '{dout: '0, drive: '1};
		fn_a_i   = '{dout: '0, drive: '0};
		fn_b_i   = '{dout: '1, drive: '1};
		pad_i    = '1;
		// strap defaults for boot codes 000, 010 and 101 with both rmii settings, and 111 with rmii clear
		for (int k = 0; k < 7; k++) begin
			do_reset(code_tab[k], k[0], k[1]);
			check_state({13'h0000, code_tab[k], 12'h000, code_tab[k], k[0]}, {30'h0000_0000, k[1], 1'b0});
		end
		// software reselection after reset
		do_reset(BOOT_NAND, 1'b0, 1'b0);
		for (int k = 0; k < 9; k++) begin
			reg_wr(FSEL0_ADDR, wr_tab[k][0], 1'b0);
			reg_wr(FSEL1_ADDR, wr_tab[k][1], 1'b0);
			repeat (4) @(posedge mclk_i);
			check_state(wr_tab[k][0] | 32'h0005_0000, wr_tab[k][1]);
		end
		// unmapped address is refused and changes nothing
		reg_rd(32'h01C4_0008, 32'h0000_0000, 1'b1, "unmapped");
		reg_wr(32'h01C4_0008, 32'h0000_0400, 1'b1);
		check_state(32'h0005_0000, 32'h0000_0000);
		end_sim();
	end

endmodule
`default_nettype wire
